// *** src/sfm_fifo.sv ***
// Word FIFO with optional overwrite of the oldest entry when full
module sfm_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic overwrite,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic full, push, pop, drop;

  // Pointer arithmetic; depth must be a power of two so pointers wrap freely
  always_comb begin
    full = (cnt_q == (AW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    in_ready = !full || overwrite;
    out_data = mem[rp_q];
    level = cnt_q;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    drop = push && full && !pop; // Oldest word gives way to the new one
    wp_d = push ? wp_q + AW'(1) : wp_q;
    rp_d = (pop || drop) ? rp_q + AW'(1) : rp_q;
    cnt_d = cnt_q;
    if (push && !(pop || drop)) begin
      cnt_d = cnt_q + (AW+1)'(1);
    end else if (!push && pop) begin
      cnt_d = cnt_q - (AW+1)'(1);
    end
  end

  // Storage has no reset; it is never read while empty
  always_ff @(posedge clk_sys) begin
    if (ce && push) begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : sfm_fifo

// *** src/sfm_packer.sv ***
// Turns one sample into the 16-bit FIFO words its format code asks for
module sfm_packer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic smp_valid,
  output logic smp_ready,
  input wire sfm_pkg::sfm_sample_t smp,
  input wire logic [2:0] fmt,
  input wire logic avg_mode,
  input wire logic [2:0] avg_shift,
  output logic word_valid,
  input wire logic word_ready,
  output logic [15:0] word_data
);
  typedef enum logic {PK_IDLE, PK_EMIT} sfm_pk_state_t;
  sfm_pk_state_t st_q, st_d;
  logic [7:0][15:0] buf_q, buf_d, words;
  logic [3:0] cnt_q, cnt_d, idx_q, idx_d, n;
  logic [31:0] sum, ext, ch0_avg;
  logic [15:0] ch0_avg_hi;

  // Word list per format; high half of a 32-bit value goes first
  always_comb begin
    words = '0;
    n = 4'h0;
    ext = 32'h0000_0000;
    sum = smp.chan[0] + smp.chan[1] + smp.chan[2] + smp.chan[3];
    case (fmt)
      sfm_pkg::FMT_ONE16: begin
        words[0] = smp.integ ? smp.sample[15:0] : sum[15:0];
        n = 4'h1;
      end
      sfm_pkg::FMT_ONE32: begin
        words[0] = smp.integ ? smp.sample[31:16] : sum[31:16];
        words[1] = smp.integ ? smp.sample[15:0] : sum[15:0];
        n = 4'h2;
      end
      sfm_pkg::FMT_PAIR16: begin
        if (smp.integ) begin
          words[0] = smp.sample[15:0];
          words[1] = smp.bgnd[15:0];
          n = 4'h2;
        end
      end
      sfm_pkg::FMT_PAIR32: begin
        if (smp.integ) begin
          words[0] = smp.sample[31:16];
          words[1] = smp.sample[15:0];
          words[2] = smp.bgnd[31:16];
          words[3] = smp.bgnd[15:0];
        end else begin
          for (int i = 0; i < 4; i++) begin
            words[i] = smp.chan[i][15:0];
          end
        end
        n = 4'h4;
      end
      sfm_pkg::FMT_EXT32: begin
        if (!smp.integ) begin
          for (int i = 0; i < 4; i++) begin
            ext = avg_mode ? (smp.chan[i] >> avg_shift) : smp.chan[i];
            words[2*i] = ext[31:16];
            words[2*i+1] = ext[15:0];
          end
          n = 4'h8;
        end
      end
      default: n = 4'h0; // Reserved and zero codes push nothing
    endcase
  end

  // Hand-off and emission sequence
  always_comb begin
    st_d = st_q;
    buf_d = buf_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    smp_ready = 1'b0;
    word_valid = 1'b0;
    word_data = buf_q[idx_q[2:0]];
    case (st_q)
      PK_IDLE: begin
        smp_ready = 1'b1;
        if (smp_valid && n != 4'h0) begin
          buf_d = words;
          cnt_d = n;
          idx_d = 4'h0;
          st_d = PK_EMIT;
        end
      end
      PK_EMIT: begin
        word_valid = 1'b1;
        if (word_ready) begin
          idx_d = idx_q + 4'h1;
          if (idx_d == cnt_q) begin
            st_d = PK_IDLE;
          end
        end
      end
      default: st_d = PK_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= PK_IDLE;
      buf_q <= '0;
      cnt_q <= 4'h0;
      idx_q <= 4'h0;
    end else if (ce) begin
      st_q <= st_d;
      buf_q <= buf_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
    end
  end

  assign ch0_avg = smp.chan[0] >> avg_shift;
  assign ch0_avg_hi = ch0_avg[31:16];

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_ext_count: assert property (ce && smp_ready && smp_valid && fmt == sfm_pkg::FMT_EXT32 && !smp.integ
    |=> cnt_q == 4'h8 && st_q == PK_EMIT) else $error("extended format did not load eight words");
  chk_one32_count: assert property (ce && smp_ready && smp_valid && fmt == sfm_pkg::FMT_ONE32
    |=> cnt_q == 4'h2) else $error("32-bit single format did not load two words");
  chk_pair16_count: assert property (ce && smp_ready && smp_valid && fmt == sfm_pkg::FMT_PAIR16 && smp.integ
    |=> cnt_q == 4'h2 && buf_q[1] == $past(smp.bgnd[15:0])) else $error("16-bit pair format wrong");
  chk_avg_word: assert property (ce && smp_ready && smp_valid && fmt == sfm_pkg::FMT_EXT32 && !smp.integ && avg_mode
    |=> buf_q[0] == $past(ch0_avg_hi)) else $error("average readback word wrong");
endmodule : sfm_packer

// *** src/sfm_pkg.sv ***
// Shared constants and carrier types for the slot FIFO mode configuration block
package sfm_pkg;
  // Register offsets on the register access port
  localparam logic [7:0] ADDR_MODE = 8'h10;
  localparam logic [7:0] ADDR_SLOT = 8'h11;
  // Field positions inside the slot control register
  localparam int SLOT_A_EN_BIT = 0;
  localparam int FMT_A_LSB = 2;
  localparam int SLOT_B_EN_BIT = 5;
  localparam int FMT_B_LSB = 6;
  localparam int OVR_BIT = 12;
  localparam int RDOUT_BIT = 13;
  // Values after reset, writable bit mask and the undefined mode code
  localparam logic [15:0] SLOT_RST = 16'h1000;
  localparam logic [15:0] SLOT_WMASK = 16'h31fd;
  localparam logic [1:0] MODE_ILLEGAL = 2'h3;
  // Operating modes
  typedef enum logic [1:0] {SFM_STANDBY = 2'h0, SFM_PROGRAM = 2'h1, SFM_NORMAL = 2'h2} sfm_mode_t;
  // FIFO data format codes
  localparam logic [2:0] FMT_NONE = 3'h0;
  localparam logic [2:0] FMT_ONE16 = 3'h1;
  localparam logic [2:0] FMT_ONE32 = 3'h2;
  localparam logic [2:0] FMT_PAIR16 = 3'h3;
  localparam logic [2:0] FMT_PAIR32 = 3'h4;
  localparam logic [2:0] FMT_EXT32 = 3'h6;
  // Data path sizes
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 16;
  // One finished sample from the sampling engine
  typedef struct packed {
    logic slot_b;
    logic integ;
    logic [31:0] sample;
    logic [31:0] bgnd;
    logic [3:0][31:0] chan;
  } sfm_sample_t;
  // One register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } sfm_reg_req_t;
endpackage : sfm_pkg

// *** src/sfm_slot_fifo_mode_config.sv ***
// Operating mode and time-slot control registers steering the sample FIFO path
// Function
// - Mode codes standby, program, normal; resets standby
// - Bit 13 picks block sum or average
// - Protection clear: full FIFO overwrites oldest
// - Protection set: write only while not full
// - Slot B format field; code 0 none
// - Codes 1, 2: one 16/32-bit word
// - Codes 3, 4: sample plus background, or channels for code 4 only
// - Code 6: four 32-bit extended channels
// - Bit 5 enables slot B measurement
// - Slot A format field, same codes
// - Bit 0 enables slot A measurement
module sfm_slot_fifo_mode_config (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire sfm_pkg::sfm_reg_req_t reg_req,
  output logic [15:0] reg_rdata_q,
  output logic reg_rvalid_q,
  input wire logic smp_valid,
  input wire sfm_pkg::sfm_sample_t smp_in,
  output logic smp_ready_q,
  input wire logic [2:0] avg_shift,
  output logic out_valid_q,
  output logic [15:0] out_data_q,
  input wire logic out_ready,
  output sfm_pkg::sfm_mode_t op_mode_q,
  output logic first_slot_run_q,
  output logic second_slot_run_q,
  output logic extended_readback_sum_or_average_q,
  output logic [4:0] fifo_level_q
);
  // Register state
  logic [15:0] slot_q, slot_d;
  sfm_pkg::sfm_mode_t mode_d;
  logic [15:0] rdata_d;
  logic rvalid_d;
  logic run_a_d, run_b_d, ext_d;

  // Fields of the slot control register
  logic first_slot_enable, second_slot_enable;
  logic [2:0] first_slot_fifo_format, second_slot_fifo_format;
  logic fifo_overflow_protect, extended_readback_sum_or_average;

  // Sample hold stage
  sfm_pkg::sfm_sample_t hold_q, hold_d;
  logic hold_vld_q, hold_vld_d, smp_ready_d;
  logic smp_take, smp_keep;
  logic [2:0] hold_fmt;

  // Packer and FIFO wiring
  logic pk_ready, pk_wvalid, pk_wready;
  logic [15:0] pk_wdata;
  logic ff_ovalid, ff_oready, ff_full;
  logic [15:0] ff_odata;
  logic [4:0] ff_level;

  // Output stage
  logic out_valid_d;
  logic [15:0] out_data_d;

  // Field decode of the slot control register
  always_comb begin
    first_slot_enable = slot_q[sfm_pkg::SLOT_A_EN_BIT];
    second_slot_enable = slot_q[sfm_pkg::SLOT_B_EN_BIT];
    first_slot_fifo_format = slot_q[sfm_pkg::FMT_A_LSB +: 3];
    second_slot_fifo_format = slot_q[sfm_pkg::FMT_B_LSB +: 3];
    fifo_overflow_protect = slot_q[sfm_pkg::OVR_BIT];
    extended_readback_sum_or_average = slot_q[sfm_pkg::RDOUT_BIT];
  end

  // Register writes and reads; a read in the same cycle as a write returns the old value
  always_comb begin
    slot_d = slot_q;
    mode_d = op_mode_q;
    rdata_d = 16'h0000;
    rvalid_d = 1'b0;
    // Code 3 names no mode, so a write of it leaves the mode as it was
    if (reg_req.wr) begin
      if (reg_req.addr == sfm_pkg::ADDR_MODE && reg_req.wdata[1:0] != sfm_pkg::MODE_ILLEGAL) begin
        mode_d = sfm_pkg::sfm_mode_t'(reg_req.wdata[1:0]);
      end
      if (reg_req.addr == sfm_pkg::ADDR_SLOT) begin
        slot_d = reg_req.wdata & sfm_pkg::SLOT_WMASK; // Reserved bits are not stored
      end
    end
    if (reg_req.rd) begin
      rvalid_d = 1'b1;
      case (reg_req.addr)
        sfm_pkg::ADDR_MODE: rdata_d = {14'h0000, op_mode_q};
        sfm_pkg::ADDR_SLOT: rdata_d = slot_q;
        default: rdata_d = 16'h0000; // Unmapped offsets read as zero
      endcase
    end
    // Slots only run in normal operation
    run_a_d = slot_d[sfm_pkg::SLOT_A_EN_BIT] && mode_d == sfm_pkg::SFM_NORMAL;
    run_b_d = slot_d[sfm_pkg::SLOT_B_EN_BIT] && mode_d == sfm_pkg::SFM_NORMAL;
    ext_d = slot_d[sfm_pkg::RDOUT_BIT];
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slot_q <= sfm_pkg::SLOT_RST;
      op_mode_q <= sfm_pkg::SFM_STANDBY;
      reg_rdata_q <= 16'h0000;
      reg_rvalid_q <= 1'b0;
      first_slot_run_q <= 1'b0;
      second_slot_run_q <= 1'b0;
      extended_readback_sum_or_average_q <= 1'b0;
    end else if (ce) begin
      slot_q <= slot_d;
      op_mode_q <= mode_d;
      reg_rdata_q <= rdata_d;
      reg_rvalid_q <= rvalid_d;
      first_slot_run_q <= run_a_d;
      second_slot_run_q <= run_b_d;
      extended_readback_sum_or_average_q <= ext_d;
    end
  end

  // Sample hold: one slot of buffering so the ready output comes from a flop.
  // Costs half throughput on back-to-back samples, which the sample rate never needs.
  always_comb begin
    smp_take = smp_valid && smp_ready_q;
    smp_keep = smp_take && (smp_in.slot_b ? second_slot_run_q : first_slot_run_q);
    hold_d = hold_q;
    hold_vld_d = hold_vld_q && !pk_ready;
    if (smp_keep) begin
      hold_d = smp_in;
      hold_vld_d = 1'b1;
    end
    smp_ready_d = !hold_vld_d;
    hold_fmt = hold_q.slot_b ? second_slot_fifo_format : first_slot_fifo_format;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_q <= '0;
      hold_vld_q <= 1'b0;
      smp_ready_q <= 1'b0;
    end else if (ce) begin
      hold_q <= hold_d;
      hold_vld_q <= hold_vld_d;
      smp_ready_q <= smp_ready_d;
    end
  end

  // Format expansion; slot A uses the same code table as slot B
  sfm_packer u_packer (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .smp_valid(hold_vld_q),
    .smp_ready(pk_ready),
    .smp(hold_q),
    .fmt(hold_fmt),
    .avg_mode(extended_readback_sum_or_average),
    .avg_shift(avg_shift),
    .word_valid(pk_wvalid),
    .word_ready(pk_wready),
    .word_data(pk_wdata)
  );

  // Overwrite mode keeps the FIFO always ready; protect mode stalls the packer when full
  sfm_fifo #(
    .W(sfm_pkg::WORD_W),
    .DEPTH(sfm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .overwrite(!fifo_overflow_protect),
    .in_valid(pk_wvalid),
    .in_ready(pk_wready),
    .in_data(pk_wdata),
    .out_valid(ff_ovalid),
    .out_ready(ff_oready),
    .out_data(ff_odata),
    .level(ff_level)
  );

  // Output register in front of the reader
  // The held word sits outside the FIFO count, so 17 words can wait in all
  always_comb begin
    ff_full = (ff_level == 5'(sfm_pkg::FIFO_DEPTH));
    ff_oready = !out_valid_q || out_ready;
    out_valid_d = ff_oready ? ff_ovalid : out_valid_q;
    out_data_d = (ff_oready && ff_ovalid) ? ff_odata : out_data_q;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_valid_q <= 1'b0;
      out_data_q <= 16'h0000;
      fifo_level_q <= 5'h00;
    end else if (ce) begin
      out_valid_q <= out_valid_d;
      out_data_q <= out_data_d;
      fifo_level_q <= ff_level; // Lags the FIFO by one cycle
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Mode register
  chk_mode_write: assert property (ce && reg_req.wr && reg_req.addr == sfm_pkg::ADDR_MODE
    && reg_req.wdata[1:0] != sfm_pkg::MODE_ILLEGAL |=> op_mode_q == $past(reg_req.wdata[1:0]))
    else $error("mode write not taken");
  chk_mode_illegal: assert property (ce && reg_req.wr && reg_req.addr == sfm_pkg::ADDR_MODE
    && reg_req.wdata[1:0] == sfm_pkg::MODE_ILLEGAL |=> $stable(op_mode_q))
    else $error("undefined mode code changed mode");

  // Slot enables and readback selector
  chk_run_a: assert property (first_slot_run_q == (first_slot_enable && op_mode_q == sfm_pkg::SFM_NORMAL))
    else $error("slot A run flag wrong");
  chk_run_b: assert property (second_slot_run_q == (second_slot_enable && op_mode_q == sfm_pkg::SFM_NORMAL))
    else $error("slot B run flag wrong");
  chk_drop_idle: assert property (ce && smp_take && !(smp_in.slot_b ? second_slot_run_q : first_slot_run_q)
    |=> !hold_vld_q) else $error("sample of idle slot was kept");
  chk_readback_sel: assert property (extended_readback_sum_or_average_q == slot_q[sfm_pkg::RDOUT_BIT])
    else $error("readback selector out of step");

  // Overflow behaviour
  chk_ovr_block: assert property (fifo_overflow_protect && ff_full |-> !pk_wready)
    else $error("write accepted into full FIFO");
  chk_wrap_accept: assert property (!fifo_overflow_protect |-> pk_wready)
    else $error("wrap mode refused a word");
  chk_wrap_full: assert property (ce && !fifo_overflow_protect && ff_full && pk_wvalid && !ff_oready
    |=> ff_level == 5'(sfm_pkg::FIFO_DEPTH)) else $error("wrap lost fill level");

  // Formats and stalled output
  chk_fmt_none: assert property (ce && hold_vld_q && pk_ready && hold_fmt == sfm_pkg::FMT_NONE
    |=> !pk_wvalid) else $error("format zero pushed data");
  chk_out_stable: assert property (out_valid_q && !out_ready |=> out_valid_q && $stable(out_data_q))
    else $error("output word dropped while stalled");

  // Register port answers; a read sees the value from before a same-cycle write
  chk_read_pulse: assert property (ce && reg_req.rd
    |=> reg_rvalid_q)
    else $error("read got no answer");
  chk_read_quiet: assert property (ce && !reg_req.rd
    |=> !reg_rvalid_q)
    else $error("answer without a read");
  chk_read_mode: assert property (ce && reg_req.rd && reg_req.addr == sfm_pkg::ADDR_MODE
    |=> reg_rdata_q == {14'h0000, $past(op_mode_q)})
    else $error("mode readback wrong");
  chk_read_slot: assert property (ce && reg_req.rd && reg_req.addr == sfm_pkg::ADDR_SLOT
    |=> reg_rdata_q == $past(slot_q))
    else $error("slot readback wrong");

  // Registers move only on a write to their own offset, and never with ce low
  chk_slot_write: assert property (ce && reg_req.wr && reg_req.addr == sfm_pkg::ADDR_SLOT
    |=> slot_q == ($past(reg_req.wdata) & sfm_pkg::SLOT_WMASK))
    else $error("slot write not stored");
  chk_slot_keep: assert property (ce && !(reg_req.wr && reg_req.addr == sfm_pkg::ADDR_SLOT)
    |=> $stable(slot_q))
    else $error("slot register moved");
  chk_mode_keep: assert property (ce && !(reg_req.wr && reg_req.addr == sfm_pkg::ADDR_MODE)
    |=> $stable(op_mode_q))
    else $error("mode moved");
  chk_ce_freeze: assert property (!ce
    |=> $stable(slot_q) && $stable(hold_vld_q) && $stable(out_valid_q))
    else $error("state moved with ce low");
  chk_standby_idle: assert property (op_mode_q != sfm_pkg::SFM_NORMAL
    |-> !first_slot_run_q && !second_slot_run_q)
    else $error("slot runs outside normal mode");

  // Sample hold hand-off
  chk_keep_hold: assert property (ce && smp_keep
    |=> hold_vld_q && !smp_ready_q)
    else $error("kept sample not held");
  chk_hold_pass: assert property (ce && hold_vld_q && pk_ready
    |=> !hold_vld_q)
    else $error("held sample not passed on");
  chk_ready_back: assert property (ce && !hold_vld_q && !smp_keep
    |=> smp_ready_q)
    else $error("ready did not return");

  // Fill level and output register
  chk_level_cap: assert property (ff_level <= 5'(sfm_pkg::FIFO_DEPTH))
    else $error("fill level above depth");
  chk_level_reg: assert property (ce
    |=> fifo_level_q == $past(ff_level))
    else $error("level output out of step");
  chk_protect_full: assert property (ce && fifo_overflow_protect && ff_full
    && !ff_oready |=> ff_full)
    else $error("protected FIFO lost a word");
  chk_out_load: assert property (ce && ff_ovalid && ff_oready
    |=> out_valid_q && out_data_q == $past(ff_odata))
    else $error("output word not loaded");
  chk_out_drain: assert property (ce && out_valid_q && out_ready && !ff_ovalid
    |=> !out_valid_q)
    else $error("output valid stuck");

  cov_wrap: cover property (!fifo_overflow_protect && ff_full && pk_wvalid);
  cov_slot_b: cover property (ce && smp_keep && smp_in.slot_b);
  cov_full_protect: cover property (fifo_overflow_protect && ff_full && pk_wvalid ##1 ff_oready);
  cov_avg_ext: cover property (ce && hold_vld_q && pk_ready && extended_readback_sum_or_average
    && hold_fmt == sfm_pkg::FMT_EXT32);
  cov_program: cover property (op_mode_q == sfm_pkg::SFM_PROGRAM);
endmodule : sfm_slot_fifo_mode_config

// *** verif/sfm_host_model.sv ***
// Host side register master model for the slot FIFO mode configuration block
module sfm_host_model (
  input wire logic clk_sys,
  output sfm_pkg::sfm_reg_req_t reg_req,
  input wire logic [15:0] reg_rdata_q,
  input wire logic reg_rvalid_q
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle request from time zero so nothing is taken during reset
  initial reg_req = '0;

  // One-cycle write request; released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    reg_req <= '0;
  endtask : wr

  // Read request; the answer pulse is registered at the taking edge and read 1 ns later
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_sys);
    reg_req <= '0;
    #1;
    v = reg_rvalid_q;
    d = reg_rdata_q;
  endtask : rd
endmodule : sfm_host_model

// *** verif/tb_slot_fifo_mode_config.sv ***
// Self-checking bench for the slot FIFO mode configuration block
module tb_slot_fifo_mode_config;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] a; logic [15:0] d; logic [15:0] e;} sfm_row_t;
  // Register rows: address, written value, value read back
  localparam sfm_row_t ROWS [6] = '{'{8'h10, 16'h0001, 16'h0001}, '{8'h10, 16'h0002, 16'h0002},
    '{8'h10, 16'h0003, 16'h0002}, '{8'h11, 16'hffff, 16'h31fd}, '{8'h11, 16'h0000, 16'h0000},
    '{8'h20, 16'hffff, 16'h0000}};
  logic clk_sys, rst, ce, smp_valid, out_ready, reg_rvalid_q, smp_ready_q, out_valid_q, rd_v;
  logic first_slot_run_q, second_slot_run_q, ext_q;
  logic [2:0] avg_shift;
  logic [4:0] fifo_level_q;
  logic [15:0] reg_rdata_q, out_data_q, rd_d, cfg;
  logic [15:0] got[$], exp_q[$];
  sfm_pkg::sfm_sample_t smp_in;
  sfm_pkg::sfm_reg_req_t reg_req;
  sfm_pkg::sfm_mode_t op_mode_q;
  int fails, compares;

  sfm_slot_fifo_mode_config dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_req(reg_req),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .smp_valid(smp_valid), .smp_in(smp_in),
    .smp_ready_q(smp_ready_q), .avg_shift(avg_shift), .out_valid_q(out_valid_q), .out_data_q(out_data_q),
    .out_ready(out_ready), .op_mode_q(op_mode_q), .first_slot_run_q(first_slot_run_q),
    .second_slot_run_q(second_slot_run_q), .extended_readback_sum_or_average_q(ext_q),
    .fifo_level_q(fifo_level_q));
  sfm_host_model host (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q));

  // Free running system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Collect every word the reader accepts
  always @(posedge clk_sys) begin
    if (out_valid_q === 1'b1 && out_ready === 1'b1) got.push_back(out_data_q);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    compares++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // Distinct values per sample index so lost or reordered words show
  function automatic sfm_pkg::sfm_sample_t mk(input logic b, input logic ig, input logic [7:0] k);
    mk.slot_b = b;
    mk.integ = ig;
    mk.sample = {8'ha1, k, 8'h8f, k};
    mk.bgnd = {8'hb2, k, 8'h7e, k};
    for (int i = 0; i < 4; i++) mk.chan[i] = {4'h1, 4'(i), k, 8'h30, k};
  endfunction : mk

  function automatic void push32(input logic [31:0] v);
    exp_q.push_back(v[31:16]);
    exp_q.push_back(v[15:0]);
  endfunction : push32

  // Expected FIFO words of one sample, high half first
  function automatic void expect_words(input sfm_pkg::sfm_sample_t s, input logic [2:0] f, input logic av,
    input logic [2:0] sh);
    logic [31:0] sum;
    sum = s.chan[0] + s.chan[1] + s.chan[2] + s.chan[3];
    case (f)
      3'h1: exp_q.push_back(s.integ ? s.sample[15:0] : sum[15:0]);
      3'h2: push32(s.integ ? s.sample : sum);
      3'h3: if (s.integ) begin
        exp_q.push_back(s.sample[15:0]);
        exp_q.push_back(s.bgnd[15:0]);
      end
      3'h4: if (s.integ) begin
        push32(s.sample);
        push32(s.bgnd);
      end else begin
        for (int i = 0; i < 4; i++) exp_q.push_back(s.chan[i][15:0]);
      end
      3'h6: if (!s.integ) begin
        for (int i = 0; i < 4; i++) push32(av ? s.chan[i] >> sh : s.chan[i]);
      end
      default: ;
    endcase
  endfunction : expect_words

  // Hold one sample until an edge samples ready high; bounded wait
  task automatic send(input sfm_pkg::sfm_sample_t s);
    int n;
    n = 0;
    @(posedge clk_sys);
    smp_in <= s;
    smp_valid <= 1'b1;
    @(posedge clk_sys);
    while (smp_ready_q !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    smp_valid <= 1'b0;
    check(n < 200, 1'b1, "ready wait");
  endtask : send

  // Compare collected words against the expected list, then clear both
  task automatic cmpq();
    check(got.size(), exp_q.size(), "word count");
    foreach (exp_q[i]) check(got[i], exp_q[i], "word");
    got.delete();
    exp_q.delete();
  endtask : cmpq

  // Watchdog sized well beyond the full sequence
  initial begin
    #200000;
    fails++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    smp_valid = 1'b0;
    out_ready = 1'b1;
    avg_shift = 3'h0;
    smp_in = '0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    check(op_mode_q, sfm_pkg::SFM_STANDBY, "mode reset");
    check(ext_q, 1'b0, "sum flag reset");
    host.rd(sfm_pkg::ADDR_SLOT, rd_d, rd_v);
    check(rd_d, 16'h1000, "slot reset");
    // Register rows, reserved bits and an unmapped address among them
    foreach (ROWS[i]) begin
      host.wr(ROWS[i].a, ROWS[i].d);
      host.rd(ROWS[i].a, rd_d, rd_v);
      check(rd_v, 1'b1, "read pulse");
      check(rd_d, ROWS[i].e, "reg row");
    end
    // Every format code of both slots, with and without integration
    for (int b = 0; b < 2; b++) begin
      for (int f = 0; f < 8; f++) begin
        for (int ig = 0; ig < 2; ig++) begin
          // The unused slot keeps format 0, so slot B stays legal
          cfg = b ? (16'h1020 | (16'(f) << 6)) : (16'h1001 | (16'(f) << 2));
          host.wr(sfm_pkg::ADDR_SLOT, cfg);
          #1;
          check(first_slot_run_q, b == 0, "first run");
          check(second_slot_run_q, b == 1, "second run");
          send(mk(!b, ig, 8'(f)));
          send(mk(b, ig, 8'(f)));
          expect_words(mk(b, ig, 8'(f)), 3'(f), 1'b0, 3'h0);
          repeat (24) @(posedge clk_sys);
          cmpq();
        end
      end
    end
    // Average readback shifts extended words
    host.wr(sfm_pkg::ADDR_SLOT, 16'h3019);
    avg_shift <= 3'h2;
    #1;
    check(ext_q, 1'b1, "average flag");
    send(mk(1'b0, 1'b0, 8'h5a));
    expect_words(mk(1'b0, 1'b0, 8'h5a), 3'h6, 1'b1, 3'h2);
    repeat (24) @(posedge clk_sys);
    cmpq();
    // Stalled reader: protection stalls, wrap keeps the newest words
    for (int p = 1; p >= 0; p--) begin
      host.wr(sfm_pkg::ADDR_SLOT, p ? 16'h1019 : 16'h0019);
      @(posedge clk_sys);
      out_ready <= 1'b0;
      for (int k = 1; k < 4; k++) begin
        send(mk(1'b0, 1'b0, 8'(k)));
        expect_words(mk(1'b0, 1'b0, 8'(k)), 3'h6, 1'b0, 3'h0);
      end
      repeat (30) @(posedge clk_sys);
      check(fifo_level_q, 5'h10, "level full");
      if (p == 0) exp_q = {exp_q[0], exp_q[8:$]};
      @(posedge clk_sys);
      out_ready <= 1'b1;
      repeat (40) @(posedge clk_sys);
      cmpq();
    end
    // Program mode holds both slots idle
    host.wr(sfm_pkg::ADDR_SLOT, 16'h1021);
    host.wr(sfm_pkg::ADDR_MODE, 16'h0001);
    #1;
    check(first_slot_run_q | second_slot_run_q, 1'b0, "program idle");
    // Clock enable low freezes the registers
    ce <= 1'b0;
    host.wr(sfm_pkg::ADDR_MODE, 16'h0002);
    #1;
    check(op_mode_q, sfm_pkg::SFM_PROGRAM, "frozen mode");
    ce <= 1'b1;
    // Second reset in mid run restores defaults
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    host.rd(sfm_pkg::ADDR_SLOT, rd_d, rd_v);
    check(rd_d, 16'h1000, "slot reset again");
    check(op_mode_q, sfm_pkg::SFM_STANDBY, "mode reset again");
    summarize();
  end
endmodule : tb_slot_fifo_mode_config
